// [design/dgd_params.svh]
/*
 * Constants of the dual gate drive control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 25 MHz pclk; included by its bare name.
 */
`ifndef DGD_PARAMS_SVH
`define DGD_PARAMS_SVH

// Clock period in ns
`define DGD_CLK_NS        40
// Gap time slope in ps per kilohm and offset in ps
`define DGD_GAP_SLOPE_PS  1730
`define DGD_GAP_OFFS_PS   5740
// Default gap resistor in kilohm
`define DGD_GAP_RES_KOHM  10
// Gap cycles, least time so rounded up
`define DGD_GAP_CYC  ((`DGD_GAP_SLOPE_PS*`DGD_GAP_RES_KOHM+`DGD_GAP_OFFS_PS+`DGD_CLK_NS*1000-1)/(`DGD_CLK_NS*1000))
// Strong pull-low hold time in us, then in cycles (rounded down)
`define DGD_HOLD_US       1000
`define DGD_HOLD_CYC      (`DGD_HOLD_US*1000/`DGD_CLK_NS)
// Deglitch filter length in cycles
`define DGD_GLITCH_CYC    4

// Register byte offsets
`define DGD_CTRL_OFS      12'h000
`define DGD_GAP_OFS       12'h004
`define DGD_STAT_OFS      12'h008
// Control reset value: dual input, shutoff variant, protection on
`define DGD_CTRL_RST      4'h0
// Status field positions
`define DGD_ST_LOCK_LSB   0
`define DGD_ST_THA_LSB    3
`define DGD_ST_THB_LSB    5
`define DGD_ST_OUT_LSB    7
`define DGD_ST_BYP_BIT    9

`endif

// [design/dgd_pkg.sv]
/*
 * Types of the dual gate drive control block.
 * Assumes dgd_params.svh holds all numbers.
 */
package dgd_pkg;

    // Software configuration bits
    typedef struct packed {
        logic deglitch_en;  // Filter control inputs
        logic bypass;       // No gap, no overlap guard
        logic en_variant;   // 1: enable pin gates, 0: shutoff pin gates
        logic phase_mode;   // 1: single phase input
    } dgd_cfg_t;

    // Control pins after synchronising
    typedef struct packed {
        logic shutoff;
        logic enable;
        logic phase;
        logic chan_b;
        logic chan_a;
    } dgd_pins_t;

    // Thermal states of one channel
    typedef enum logic [1:0] {
        DGD_TH_RUN,
        DGD_TH_STRONG,
        DGD_TH_WEAK
    } dgd_therm_t;

endpackage

// [design/dgd_deglitch.sv]
/*
 * Deglitch filter for a bundle of synchronised inputs.
 * Assumes inputs already pass a two-flop synchroniser.
 */
`timescale 1ns/10ps
module dgd_deglitch #(
    parameter int WIDTH = 5,
    parameter int CYC   = 4
)(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             en,
    // Data
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] clean
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic [15:0] cnt_r;  // Cycles the input has differed

            // A change must stand CYC cycles before it passes
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cnt_r    <= 16'h0000;
                    clean[i] <= 1'b0;
                end
                else if (!en || raw[i] == clean[i])
                begin
                    // Filter off or no change pending
                    cnt_r    <= 16'h0000;
                    clean[i] <= raw[i];
                end
                else if (cnt_r == 16'(CYC - 1))
                begin
                    cnt_r    <= 16'h0000;
                    clean[i] <= raw[i];
                end
                else
                    cnt_r <= cnt_r + 16'h0001;
            end

            short_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
                ($past(en) && $changed(clean[i]) && $past(raw[i] != clean[i]))
                |-> $past(cnt_r) == 16'(CYC - 1))
                else $error("filtered input changed early");
        end
    endgenerate

endmodule // dgd_deglitch

// [design/dgd_thermal.sv]
/*
 * Thermal hold sequencer for one channel.
 * Assumes trip is a synchronised flag, high from trip until release level.
 */
`timescale 1ns/10ps
module dgd_thermal #(
    parameter int HOLD = 25000
)(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Sensor flag
    input  wire logic                trip,
    // State
    output dgd_pkg::dgd_therm_t      state
);

    logic [31:0] cnt_r;  // Cycles spent in strong pull-low

    // Strong pull-low first, weak after the hold time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= dgd_pkg::DGD_TH_RUN;
            cnt_r <= 32'h0000_0000;
        end
        else
        begin
            unique case (state)
                dgd_pkg::DGD_TH_RUN:
                begin
                    cnt_r <= 32'h0000_0000;
                    if (trip)
                        state <= dgd_pkg::DGD_TH_STRONG;
                end
                dgd_pkg::DGD_TH_STRONG:
                begin
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (!trip)
                        state <= dgd_pkg::DGD_TH_RUN;
                    else if (cnt_r == 32'(HOLD - 1))
                        state <= dgd_pkg::DGD_TH_WEAK;
                end
                dgd_pkg::DGD_TH_WEAK:
                    // Weak pull-low until the flag clears
                    if (!trip)
                        state <= dgd_pkg::DGD_TH_RUN;
                default:
                    state <= dgd_pkg::DGD_TH_RUN;
            endcase
        end
    end

    weak_after_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == dgd_pkg::DGD_TH_STRONG && trip && cnt_r == 32'(HOLD - 1))
        |=> state == dgd_pkg::DGD_TH_WEAK)
        else $error("weak pull-low not entered after hold");

endmodule // dgd_thermal

// [design/dgd_gate_ctrl.sv]
/*
 * Dual gate drive control: supply lockout, input gating, deglitch,
 * gap insertion with overlap guard, thermal hold and an APB slave.
 * Assumes one 25 MHz clock; all pins except the APB bus are asynchronous to it.
 */
`timescale 1ns/10ps
`include "dgd_params.svh"
module dgd_gate_ctrl #(
    parameter int         HOLD_CYCLES   = `DGD_HOLD_CYC,
    parameter int         GLITCH_CYCLES = `DGD_GLITCH_CYC,
    parameter logic [7:0] GAP_CYCLES    = 8'(`DGD_GAP_CYC)
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Control pins
    input  wire logic        chan_a_input,
    input  wire logic        chan_b_input,
    input  wire logic        phase_input,
    input  wire logic        enable_input,
    input  wire logic        shutoff_input,
    input  wire logic        gap_setting_tied,
    // Supply comparators: [1] above rise level, [0] above fall level
    input  wire logic [1:0]  logic_supply_ok,
    input  wire logic [1:0]  chan_a_supply_ok,
    input  wire logic [1:0]  chan_b_supply_ok,
    // Over-temperature flags
    input  wire logic        overheat_a,
    input  wire logic        overheat_b,
    // Drive outputs
    output logic             chan_a_output,
    output logic             chan_b_output,
    output logic             clamp_a,
    output logic             clamp_b,
    output logic             weak_low_a,
    output logic             weak_low_b
);

    // Synchroniser stages for every pin
    logic [13:0]         sync1_r;
    logic [13:0]         sync2_r;
    logic [13:0]         pins_raw;
    // Synchronised and filtered control pins
    dgd_pkg::dgd_pins_t  pins_s;
    dgd_pkg::dgd_pins_t  pins_f;
    // Configuration registers
    dgd_pkg::dgd_cfg_t   cfg_r;
    logic [7:0]          gap_r;
    // Lockout per supply: 0 logic, 1 channel A, 2 channel B
    logic [2:0]          lock_r;
    logic [5:0]          sup_s;
    // Channel inputs after phase split, and their previous values
    logic [1:0]          in_v;
    logic [1:0]          prev_r;
    logic [1:0]          fall_v;
    // Gap timers per output
    logic [7:0]          timer_r [2];
    logic [7:0]          gap_load;
    // Gating and protection
    logic                bypass;
    logic                gate_on;
    logic [1:0]          drive_ok;
    logic [1:0]          out_nxt;
    logic [1:0]          out_r;
    dgd_pkg::dgd_therm_t therm [2];
    logic [1:0]          therm_low;
    // Bus decode
    logic                acc;
    logic                wr_en;
    logic                hit;
    logic [31:0]         rd_nxt;

    assign pins_raw = {overheat_b, overheat_a, chan_b_supply_ok, chan_a_supply_ok, logic_supply_ok,
                       gap_setting_tied, shutoff_input, enable_input, phase_input, chan_b_input,
                       chan_a_input};

    // Two-flop synchroniser; only the second stage is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 14'h0000;
            sync2_r <= 14'h0000;
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    assign pins_s = sync2_r[4:0];
    assign sup_s  = sync2_r[11:6];

    // Deglitch on the five control pins
    dgd_deglitch #(
        .WIDTH (5),
        .CYC   (GLITCH_CYCLES)
    ) u_deglitch (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (cfg_r.deglitch_en),
        .raw     (pins_s),
        .clean   (pins_f)
    );

    // Supply lockout with hysteresis, one monitor per supply
    genvar s;
    generate
        for (s = 0; s < 3; s++)
        begin : g_lock
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    lock_r[s] <= 1'b1;  // Locked until supplies proven
                else if (!sup_s[2*s])
                    lock_r[s] <= 1'b1;
                else if (sup_s[2*s+1])
                    lock_r[s] <= 1'b0;
            end

            lock_hyst_a: assert property (@(posedge pclk) disable iff (!presetn)
                (lock_r[s] && !sup_s[2*s+1]) |=> lock_r[s])
                else $error("lockout released below rise level");
        end
    endgenerate

    // Phase split or dual inputs; all pins active high
    always_comb
    begin
        if (cfg_r.phase_mode)
            in_v = {~pins_f.phase, pins_f.phase};
        else
            in_v = {pins_f.chan_b, pins_f.chan_a};
    end

    // Tied gap pin or software bit bypasses gap and overlap guard
    assign bypass = sync2_r[5] | cfg_r.bypass;

    // Gating input picks enable or shutoff polarity
    assign gate_on = cfg_r.en_variant ? pins_f.enable : ~pins_f.shutoff;

    // Falling edges of the channel inputs
    assign fall_v = prev_r & ~in_v;

    // Timer loads gap minus one so the rise lands gap cycles later
    assign gap_load = (gap_r == 8'h00) ? 8'h00 : gap_r - 8'h01;

    // Previous channel inputs for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_r <= 2'b00;
        else
            prev_r <= in_v;
    end

    // Gap timers and output decision per channel
    genvar c;
    generate
        for (c = 0; c < 2; c++)
        begin : g_chan
            // Other input falling loads this output's gap timer
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    timer_r[c] <= 8'h00;
                else if (fall_v[1-c])
                    timer_r[c] <= gap_load;
                else if (timer_r[c] != 8'h00)
                    timer_r[c] <= timer_r[c] - 8'h01;
            end

            // Strong or weak pull-low while overheated
            dgd_thermal #(
                .HOLD (HOLD_CYCLES)
            ) u_thermal (
                .pclk    (pclk),
                .presetn (presetn),
                .trip    (sync2_r[12+c]),
                .state   (therm[c])
            );

            assign therm_low[c] = (therm[c] != dgd_pkg::DGD_TH_RUN);

            // Lockouts and gating override everything; lockout wins over the gate
            assign drive_ok[c] = ~lock_r[0] & gate_on & ~lock_r[c+1] & ~therm_low[c];

            always_comb
            begin
                if (!drive_ok[c])
                    out_nxt[c] = 1'b0;
                else if (bypass)
                    out_nxt[c] = in_v[c];
                else if (in_v[0] && in_v[1])
                    out_nxt[c] = 1'b0;
                else
                    out_nxt[c] = in_v[c] & ~fall_v[1-c] & (timer_r[c] == 8'h00);
            end

            gap_block_a: assert property (@(posedge pclk) disable iff (!presetn)
                (fall_v[1-c] && !bypass) |=> !out_r[c])
                else $error("output rose with no gap after other input fell");

            pass_through_a: assert property (@(posedge pclk) disable iff (!presetn)
                (drive_ok[c] && !bypass && in_v[c] && !in_v[1-c] && !prev_r[1-c]
                 && timer_r[c] == 8'h00) |=> out_r[c])
                else $error("output delayed with no gap pending");

            chan_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
                lock_r[c+1] |=> !out_r[c] && (c == 0 ? clamp_a : clamp_b))
                else $error("locked channel output not low and clamped");
        end
    endgenerate

    // Output flops; delay from pin to output is fixed by the sync and filter stages unless a gap timer holds back the rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_r   <= 2'b00;
            clamp_a <= 1'b1;
            clamp_b <= 1'b1;
        end
        else
        begin
            out_r   <= out_nxt;
            clamp_a <= lock_r[1];
            clamp_b <= lock_r[2];
        end
    end

    // Weak pull-low strobes track the thermal state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            weak_low_a <= 1'b0;
            weak_low_b <= 1'b0;
        end
        else
        begin
            weak_low_a <= (therm[0] == dgd_pkg::DGD_TH_WEAK);
            weak_low_b <= (therm[1] == dgd_pkg::DGD_TH_WEAK);
        end
    end

    assign chan_a_output = out_r[0];
    assign chan_b_output = out_r[1];

    logic_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_r[0] |=> out_r == 2'b00)
        else $error("outputs driven during logic lockout");

    gate_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !gate_on |=> out_r == 2'b00)
        else $error("outputs driven while gated off");

    overlap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (in_v == 2'b11 && !bypass) |=> out_r == 2'b00)
        else $error("overlap not blocked");

    never_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        out_r == 2'b11 |-> $past(bypass))
        else $error("both outputs high with protection on");

    // Bus: one wait state, pready asserted on the second access cycle
    assign acc   = psel & penable;
    assign wr_en = acc & pready & pwrite;
    assign hit   = (paddr == `DGD_CTRL_OFS) | (paddr == `DGD_GAP_OFS) | (paddr == `DGD_STAT_OFS);

    // Read mux; reserved bits read zero
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (paddr == `DGD_CTRL_OFS)
            rd_nxt[3:0] = cfg_r;
        else if (paddr == `DGD_GAP_OFS)
            rd_nxt[7:0] = gap_r;
        else if (paddr == `DGD_STAT_OFS)
        begin
            rd_nxt[`DGD_ST_LOCK_LSB +: 3] = lock_r;
            rd_nxt[`DGD_ST_THA_LSB +: 2]  = therm[0];
            rd_nxt[`DGD_ST_THB_LSB +: 2]  = therm[1];
            rd_nxt[`DGD_ST_OUT_LSB +: 2]  = out_r;
            rd_nxt[`DGD_ST_BYP_BIT]       = bypass;
        end
    end

    // Answer flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~hit;
            prdata  <= (acc & ~pready & ~pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

    // Writable registers; gap count reset comes from the parameter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= `DGD_CTRL_RST;
            gap_r <= GAP_CYCLES;
        end
        else if (wr_en && paddr == `DGD_CTRL_OFS)
            cfg_r <= pwdata[3:0];
        else if (wr_en && paddr == `DGD_GAP_OFS)
            gap_r <= pwdata[7:0];
    end

    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && !pready) |=> pready)
        else $error("access phase not answered");

endmodule // dgd_gate_ctrl

// [tb/dgd_ctrl_model.sv]
/*
 * Controller model: drives the control pins of the gate drive block.
 * Assumes the bench hands it pin requests and one rising-edge clock.
 */
`timescale 1ns/10ps
module dgd_ctrl_model (
    // Clock
    input  wire logic               pclk,
    // Bench request and overlap guard
    input  wire dgd_pkg::dgd_pins_t req,
    input  wire logic               guard,
    // Pins toward the block
    output dgd_pkg::dgd_pins_t      pins
);
    dgd_pkg::dgd_pins_t nxt;  // Next pin word, built whole so pins get one update per edge

    // Pins start inactive so the block never sees an unknown
    initial pins = '0;

    // Pins change just after an edge, like a clocked controller
    always @(posedge pclk)
    begin
        nxt = req;
        // With the block's guard bypassed, the controller keeps the pair apart
        if (guard && req.chan_a && req.chan_b)
        begin
            nxt.chan_a = 1'b0;
            nxt.chan_b = 1'b0;
        end
        pins <= nxt;
    end
endmodule // dgd_ctrl_model

// [tb/dual_gate_drive_control_bench.sv]
/*
 * Bench of the gate drive control block: a table of pin cases, then
 * reset, gap, guard, lockout, thermal and filter cases.
 * Assumes design files and the controller model are compiled first.
 */
`timescale 1ns/10ps
module dual_gate_drive_control_bench;
    // Row: config, tie pin, pin request, expected {b,a}
    typedef struct packed {
        logic [3:0]         cfg;
        logic               tied;
        dgd_pkg::dgd_pins_t p;
        logic [1:0]         exp;
    } dgd_row_t;

    // Clock, reset and bus
    logic               pclk      = 1'b0;
    logic               presetn   = 1'b0;
    logic [11:0]        paddr     = 12'h000;
    logic               psel      = 1'b0;
    logic               penable   = 1'b0;
    logic               pwrite    = 1'b0;
    logic [31:0]        pwdata    = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    // Pins, supplies and flags
    dgd_pkg::dgd_pins_t req       = '0;
    dgd_pkg::dgd_pins_t pins;
    logic               guard     = 1'b0;
    logic               tied      = 1'b0;
    logic [1:0]         lsup      = 2'h3;
    logic [1:0]         asup      = 2'h3;
    logic [1:0]         bsup      = 2'h3;
    logic               oh_a      = 1'b0;
    logic               oh_b      = 1'b0;
    logic               out_a;
    logic               out_b;
    logic               clamp_a;
    logic               clamp_b;
    logic               weak_a;
    logic               weak_b;
    // Bookkeeping
    int                 fails     = 0;
    int                 tests_run = 0;
    logic [31:0]        rdat;
    logic               rerr;
    // Plain cases; dead time is one cycle here, so ten cycles settle all
    dgd_row_t rows [10] = '{
        {4'h0, 1'h0, 5'h01, 2'h1},
        {4'h0, 1'h0, 5'h02, 2'h2},
        {4'h0, 1'h0, 5'h03, 2'h0},
        {4'h0, 1'h0, 5'h11, 2'h0},
        {4'h2, 1'h0, 5'h09, 2'h1},
        {4'h2, 1'h0, 5'h01, 2'h0},
        {4'h1, 1'h0, 5'h04, 2'h1},
        {4'h1, 1'h0, 5'h00, 2'h2},
        {4'h4, 1'h0, 5'h03, 2'h3},
        {4'h0, 1'h1, 5'h03, 2'h3}
    };

    // 25 MHz clock
    always #20 pclk = ~pclk;

    // Block under test, thermal hold shortened to 20 cycles
    dgd_gate_ctrl #(.HOLD_CYCLES(20)) i_dgd_gate_ctrl (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_a_input(pins.chan_a),
        .chan_b_input(pins.chan_b), .phase_input(pins.phase),
        .enable_input(pins.enable), .shutoff_input(pins.shutoff),
        .gap_setting_tied(tied), .logic_supply_ok(lsup), .chan_a_supply_ok(asup),
        .chan_b_supply_ok(bsup), .overheat_a(oh_a), .overheat_b(oh_b),
        .chan_a_output(out_a), .chan_b_output(out_b), .clamp_a(clamp_a),
        .clamp_b(clamp_b), .weak_low_a(weak_a), .weak_low_b(weak_b)
    );

    // Controller on the pin side
    dgd_ctrl_model i_dgd_ctrl_model (.pclk(pclk), .req(req), .guard(guard), .pins(pins));

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Register word compare
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Output pair compare
    task automatic check_pins(input string nm, input logic [1:0] e, input logic [1:0] s);
        tests_run++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, e, s);
        end
    endtask

    // One APB transfer; the wait is bounded in case pready never comes
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            fails++;
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        check("rdata", e, rdat);
        check("slverr", {31'h0, ee}, {31'h0, rerr});
    endtask

    // Verdict and end of run
    task automatic summarize();
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        tick(4);
        presetn <= 1'b1;
        tick(6);
        foreach (rows[i])
        begin
            wr(12'h000, {28'h0, rows[i].cfg});
            tied <= rows[i].tied;
            req  <= rows[i].p;
            tick(10);
            check_pins("out", rows[i].exp, {out_b, out_a});
        end
        // Second reset in mid-run
        req     <= '0;
        tied    <= 1'b0;
        presetn <= 1'b0;
        tick(2);
        check_pins("clamp", 2'h3, {clamp_b, clamp_a});
        presetn <= 1'b1;
        rd(12'h000, 32'h0, 1'b0);
        rd(12'h004, 32'h1, 1'b0);
        rd(12'h00C, 32'h0, 1'b1);
        // Long dead time on a simultaneous swap
        wr(12'h004, 32'h6);
        rd(12'h004, 32'h6, 1'b0);
        req <= 5'h01;
        tick(8);
        req <= 5'h02;
        tick(8);
        check_pins("swap", 2'h0, {out_b, out_a});
        tick(6);
        check_pins("swap", 2'h2, {out_b, out_a});
        // Bypass with the controller guarding
        wr(12'h004, 32'h1);
        guard <= 1'b1;
        wr(12'h000, 32'h4);
        req <= 5'h03;
        tick(8);
        check_pins("guard", 2'h0, {out_b, out_a});
        rd(12'h008, 32'h200, 1'b0);
        guard <= 1'b0;
        wr(12'h000, 32'h0);
        // Channel A lockout while B runs
        req <= 5'h01;
        tick(8);
        // Below the falling level, so channel A really locks out
        asup <= 2'h0;
        tick(6);
        check_pins("clamp", 2'h1, {clamp_b, clamp_a});
        check_pins("lock", 2'h0, {out_b, out_a});
        req <= 5'h02;
        tick(8);
        check_pins("lock", 2'h2, {out_b, out_a});
        // Logic supply lockout with hysteresis; input changes ignored
        asup <= 2'h3;
        lsup <= 2'h0;
        tick(6);
        check_pins("lock", 2'h0, {out_b, out_a});
        lsup <= 2'h1;
        req  <= 5'h01;
        tick(6);
        check_pins("lock", 2'h0, {out_b, out_a});
        lsup <= 2'h3;
        tick(8);
        check_pins("lock", 2'h1, {out_b, out_a});
        // Channel B lockout while A keeps running
        bsup <= 2'h0;
        tick(6);
        check_pins("clamp", 2'h2, {clamp_b, clamp_a});
        check_pins("lock", 2'h1, {out_b, out_a});
        bsup <= 2'h3;
        // Thermal trip, weak hold, release; both channels trip together
        oh_a <= 1'b1;
        oh_b <= 1'b1;
        tick(6);
        check_pins("therm", 2'h0, {weak_a, out_a});
        tick(30);
        check_pins("therm", 2'h2, {weak_a, out_a});
        check_pins("therm_b", 2'h3, {weak_b, weak_a});
        rd(12'h008, 32'h50, 1'b0);
        oh_a <= 1'b0;
        oh_b <= 1'b0;
        tick(6);
        check_pins("therm", 2'h1, {weak_a, out_a});
        // Filter: short pulse dropped, long level passed
        wr(12'h000, 32'h8);
        req <= 5'h00;
        tick(10);
        req <= 5'h01;
        tick(2);
        req <= 5'h00;
        // Looked at while an unfiltered pulse would still stand at the output
        tick(4);
        check_pins("filter", 2'h0, {out_b, out_a});
        tick(6);
        req <= 5'h01;
        tick(12);
        check_pins("filter", 2'h1, {out_b, out_a});
        summarize();
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        #(40 * 4000);
        fails++;
        summarize();
    end
endmodule // dual_gate_drive_control_bench
